// ==== edtg_gate.sv ====
// Enclave debug and branch trace gating for one logical processor.
// Assumes core event pulses on clk_sys_i and an APB master on the same clock.
`timescale 1ns/10ps
`include "edtg_defines.svh"

// Operation
// - Flag 0 means opt-out, 1 opt-in.
// - Opt-out: suppress instruction breakpoints inside.
// - Opt-out: no data breakpoints inside range.
// - Opt-in: breakpoints evaluated without suppression.
// - Suppressed matches unrecorded; old status kept.
// - Trap-caused exit: record landing address matches.
// - Async exit saves pushed resume flag, clears synthetic.
// - Implicit, privileged, enter/resume protected accesses silent.
// - Key/report opt-in and unprotected operands fire.
// - Trap opcodes fault; opt-out gives invalid opcode.
// - Opt-in: debug/breakpoint exception, breakpoint skips privilege check.
// - Save trap address; stack gets landing address.
// - VM exit: hardware exception type 3, length zero.
// - Branch stepping: opt-in enter, synchronous exit.
// - Opt-in enter/resume/exit push own records.
// - Opt-in async exit pushes saved to landing.
// - Opt-in pushes records for inside branches.
// - Opt-out suppresses recording until leaving.
// - Opt-out exit pushes entry-to-destination record.
// - Opt-out async exit pushes two ordered records.
// - Enclave records predicted and non-transactional.
// - Enclave transitions are far branches, filterable.
module edtg_gate
  import edtg_pkg::*;
#(
  parameter int NUM_BP = `EDTG_NUM_BP
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic enter_i,
  input wire logic resume_i,
  input wire logic debug_optin_flag_i,
  input wire logic exit_i,
  input wire logic [63:0] instr_ip_i,
  input wire logic [63:0] dest_ip_i,
  input wire logic aex_i,
  input wire logic aex_trap_cause_i,
  input wire logic aex_event_push_i,
  input wire logic [63:0] aex_event_tgt_i,
  input wire logic [63:0] saved_instr_pointer_i,
  input wire logic [63:0] landing_addr_i,
  input wire logic pushed_resume_flag_i,
  input wire logic [NUM_BP-1:0] landing_ibp_match_i,
  input wire logic [63:0] enclave_range_base_i,
  input wire logic [63:0] enclave_range_limit_i,
  input wire logic [NUM_BP-1:0] ibp_match_i,
  input wire logic [NUM_BP-1:0] dbp_match_i,
  input wire logic [63:0] dbp_addr_i,
  input wire edtg_acc_t dbp_acc_kind_i,
  input wire logic dbp_acc_protected_i,
  input wire logic trap_op_valid_i,
  input wire logic [7:0] trap_opcode_i,
  input wire logic trap_vm_exit_i,
  input wire logic branch_i,
  input wire logic branch_mispred_i,
  input wire logic [63:0] branch_src_i,
  input wire logic [63:0] branch_tgt_i,
  output logic in_enclave_o,
  output logic optin_o,
  output logic [NUM_BP-1:0] ibp_fire_o,
  output logic [NUM_BP-1:0] dbp_fire_o,
  output logic step_exc_o,
  output logic exc_valid_o,
  output logic [7:0] exc_vector_o,
  output logic exc_skip_dpl_check_o,
  output logic [63:0] exc_saved_ip_o,
  output logic [63:0] exc_stack_ip_o,
  output logic vmx_valid_o,
  output logic [2:0] vmx_event_type_o,
  output logic [3:0] vmx_instr_len_o,
  output logic rf_valid_o,
  output logic rf_saved_o,
  output logic rf_synth_o,
  output logic lbr_push_o,
  output logic [63:0] lbr_source_o,
  output logic [63:0] lbr_target_o,
  output logic [1:0] lbr_txn_tag_o
);

  // ===================================================================
  // Helper functions
  function automatic logic in_range(input logic [63:0] a, input logic [63:0] b,
                                    input logic [63:0] l);
    in_range = (a >= b) && (a <= l);
  endfunction

  function automatic logic [63:0] pred_src(input logic [63:0] s);
    pred_src = s | (64'h1 << `EDTG_PRED_BIT);
  endfunction

  edtg_state_t state_reg;
  edtg_state_t state_next;

  logic setup_phase;
  logic access_phase;
  logic addr_hit;
  logic out_gated;
  logic rec_on;
  logic far_ok;
  logic [3:0] dbp_allow;
  logic [3:0] dstat_clr;

  // ===================================================================
  // APB decode
  assign setup_phase = psel_i && !penable_i;
  assign access_phase = psel_i && penable_i;

  always_comb begin
    if (paddr_i == `EDTG_OFF_CTRL) begin
      addr_hit = 1'b1;
    end else if (paddr_i == `EDTG_OFF_FILTER) begin
      addr_hit = 1'b1;
    end else if (paddr_i == `EDTG_OFF_DBG_STATUS) begin
      addr_hit = 1'b1;
    end else if (paddr_i == `EDTG_OFF_STATE) begin
      addr_hit = 1'b1;
    end else if (paddr_i == `EDTG_OFF_LBR_COUNT) begin
      addr_hit = 1'b1;
    end else begin
      addr_hit = 1'b0;
    end
  end

  assign pready_o = 1'b1;
  assign pslverr_o = access_phase && !addr_hit;

  // ===================================================================
  // Gating terms
  assign out_gated = state_reg.in_encl && !state_reg.optin;
  assign rec_on = state_reg.ctrl[`EDTG_CTRL_LBR_BIT];
  assign far_ok = !state_reg.filt_far;

  // Data breakpoint permission per access kind.
  always_comb begin
    dbp_allow = 4'h0;
    case (dbp_acc_kind_i)
      EDTG_ACC_IMPLICIT: dbp_allow = 4'h0;
      EDTG_ACC_PRIV_LEAF, EDTG_ACC_ENTER_RESUME: begin
        dbp_allow = dbp_acc_protected_i ? 4'h0 : 4'hF;
      end
      EDTG_ACC_KEY_REPORT, EDTG_ACC_OTHER_LEAF: begin
        if (!dbp_acc_protected_i) begin
          dbp_allow = 4'hF;
        end else if (dbp_acc_kind_i == EDTG_ACC_KEY_REPORT &&
                     state_reg.in_encl && state_reg.optin) begin
          dbp_allow = 4'hF;
        end else begin
          dbp_allow = 4'h0;
        end
      end
      default: begin
        if (out_gated && in_range(dbp_addr_i, enclave_range_base_i,
                                  enclave_range_limit_i)) begin
          dbp_allow = 4'h0;
        end else begin
          dbp_allow = 4'hF;
        end
      end
    endcase
  end

  // ===================================================================
  // Next state
  always_comb begin
    state_next = state_reg;
    dstat_clr = 4'h0;

    state_next.step_exc = 1'b0;
    state_next.exc_valid = 1'b0;
    state_next.vmx_valid = 1'b0;
    state_next.rf_valid = 1'b0;
    state_next.lbr_push = 1'b0;

    state_next.ibp_fire = out_gated ? 4'h0 : ibp_match_i;
    state_next.dbp_fire = dbp_match_i & dbp_allow;

    // Register writes and read data capture.
    if (setup_phase && pwrite_i) begin
      if (paddr_i == `EDTG_OFF_CTRL) begin
        state_next.ctrl = pwdata_i[1:0];
      end else if (paddr_i == `EDTG_OFF_FILTER) begin
        state_next.filt_far = pwdata_i[`EDTG_FILTER_FAR_BIT];
      end else if (paddr_i == `EDTG_OFF_DBG_STATUS) begin
        dstat_clr = pwdata_i[3:0];
      end else if (paddr_i == `EDTG_OFF_LBR_COUNT) begin
        state_next.lbr_count = 16'h0000;
      end
    end

    if (setup_phase && !pwrite_i) begin
      if (paddr_i == `EDTG_OFF_CTRL) begin
        state_next.prdata = {30'h0, state_reg.ctrl};
      end else if (paddr_i == `EDTG_OFF_FILTER) begin
        state_next.prdata = {23'h0, state_reg.filt_far, 8'h00};
      end else if (paddr_i == `EDTG_OFF_DBG_STATUS) begin
        state_next.prdata = {28'h0, state_reg.dstat};
      end else if (paddr_i == `EDTG_OFF_STATE) begin
        state_next.prdata = {29'h0, state_reg.lbr_at_entry, state_reg.optin,
                             state_reg.in_encl};
      end else if (paddr_i == `EDTG_OFF_LBR_COUNT) begin
        state_next.prdata = {16'h0, state_reg.lbr_count};
      end else begin
        state_next.prdata = 32'h0000_0000;
      end
    end

    // Debug status: set wins over clear, suppressed matches never land.
    state_next.dstat = (state_reg.dstat & ~dstat_clr) | state_next.ibp_fire |
                       state_next.dbp_fire;

    // Normal branches and the deferred second record of an async exit.
    if (state_reg.pend_push) begin
      state_next.pend_push = 1'b0;
      state_next.lbr_push = 1'b1;
      state_next.lbr_src = pred_src(state_reg.pend_src);
      state_next.lbr_tgt = state_reg.pend_tgt;
    end else if (branch_i && rec_on && !out_gated) begin
      state_next.lbr_push = 1'b1;
      state_next.lbr_src = branch_mispred_i ? branch_src_i : pred_src(branch_src_i);
      state_next.lbr_tgt = branch_tgt_i;
    end

    // Enclave entry.
    if ((enter_i || resume_i) && !state_reg.in_encl) begin
      state_next.in_encl = 1'b1;
      state_next.optin = debug_optin_flag_i;

      state_next.lbr_at_entry = rec_on;
      state_next.entry_ip = instr_ip_i;
      if (debug_optin_flag_i && enter_i && state_reg.ctrl[`EDTG_CTRL_BTF_BIT]) begin
        state_next.step_exc = 1'b1;
      end

      if (debug_optin_flag_i && rec_on && far_ok) begin
        state_next.lbr_push = 1'b1;
        state_next.lbr_src = pred_src(instr_ip_i);
        state_next.lbr_tgt = dest_ip_i;
      end
    end

    // Synchronous exit.
    if (exit_i && state_reg.in_encl) begin
      state_next.in_encl = 1'b0;
      state_next.optin = 1'b0;

      if (state_reg.ctrl[`EDTG_CTRL_BTF_BIT]) begin
        state_next.step_exc = 1'b1;
      end

      if (state_reg.optin && rec_on && far_ok) begin
        state_next.lbr_push = 1'b1;
        state_next.lbr_src = pred_src(instr_ip_i);
        state_next.lbr_tgt = dest_ip_i;
      end else if (!state_reg.optin && state_reg.lbr_at_entry && far_ok) begin
        state_next.lbr_push = 1'b1;
        state_next.lbr_src = pred_src(state_reg.entry_ip);
        state_next.lbr_tgt = dest_ip_i;
      end
    end

    // Asynchronous exit.
    if (aex_i && state_reg.in_encl) begin
      state_next.in_encl = 1'b0;
      state_next.optin = 1'b0;

      state_next.rf_valid = 1'b1;
      state_next.rf_saved = pushed_resume_flag_i;

      if (aex_trap_cause_i) begin
        state_next.dstat = state_next.dstat | landing_ibp_match_i;
      end
      if (state_reg.optin && rec_on && far_ok) begin
        state_next.lbr_push = 1'b1;
        state_next.lbr_src = pred_src(saved_instr_pointer_i);
        state_next.lbr_tgt = landing_addr_i;
      end else if (!state_reg.optin && state_reg.lbr_at_entry) begin
        if (far_ok) begin
          state_next.lbr_push = 1'b1;
          state_next.lbr_src = pred_src(state_reg.entry_ip);
          state_next.lbr_tgt = landing_addr_i;
        end

        state_next.pend_push = aex_event_push_i;
        state_next.pend_src = landing_addr_i;
        state_next.pend_tgt = aex_event_tgt_i;
      end
    end

    // Trap opcodes inside the enclave.
    if (trap_op_valid_i && state_reg.in_encl &&
        (trap_opcode_i == `EDTG_OP_DEBUG_TRAP ||
         trap_opcode_i == `EDTG_OP_BREAKPOINT)) begin
      state_next.exc_valid = 1'b1;
      state_next.exc_skip_dpl = 1'b0;

      if (!state_reg.optin) begin
        state_next.exc_vec = `EDTG_VEC_INVALID_OP;
      end else if (trap_opcode_i == `EDTG_OP_DEBUG_TRAP) begin
        state_next.exc_vec = `EDTG_VEC_DEBUG;
      end else begin
        state_next.exc_vec = `EDTG_VEC_BREAKPOINT;
        state_next.exc_skip_dpl = 1'b1;
      end

      state_next.exc_ssa_ip = instr_ip_i;
      state_next.exc_stack_ip = landing_addr_i;

      if (trap_vm_exit_i) begin
        state_next.vmx_valid = 1'b1;
        state_next.vmx_type = `EDTG_EVT_HW_EXC;
        state_next.vmx_len = `EDTG_INSTR_LEN_ZERO;
      end
    end


    if (state_next.lbr_push) begin
      state_next.lbr_count = state_reg.lbr_count + 16'h0001;
    end
  end

  // ===================================================================
  // State register
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= '0;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  // ===================================================================
  // Outputs
  assign prdata_o = state_reg.prdata;
  assign in_enclave_o = state_reg.in_encl;
  assign optin_o = state_reg.optin;
  assign ibp_fire_o = state_reg.ibp_fire;
  assign dbp_fire_o = state_reg.dbp_fire;
  assign step_exc_o = state_reg.step_exc;
  assign exc_valid_o = state_reg.exc_valid;
  assign exc_vector_o = state_reg.exc_vec;
  assign exc_skip_dpl_check_o = state_reg.exc_skip_dpl;
  assign exc_saved_ip_o = state_reg.exc_ssa_ip;
  assign exc_stack_ip_o = state_reg.exc_stack_ip;
  assign vmx_valid_o = state_reg.vmx_valid;
  assign vmx_event_type_o = state_reg.vmx_type;
  assign vmx_instr_len_o = state_reg.vmx_len;
  assign rf_valid_o = state_reg.rf_valid;
  assign rf_saved_o = state_reg.rf_saved;
  assign rf_synth_o = 1'b0;
  assign lbr_push_o = state_reg.lbr_push;
  assign lbr_source_o = state_reg.lbr_src;
  assign lbr_target_o = state_reg.lbr_tgt;
  assign lbr_txn_tag_o = `EDTG_TXN_NONE;

endmodule // edtg_gate

// ==== edtg_defines.svh ====
// Constants of the enclave debug and trace gating block.
// Assumes inclusion by the package, the design module and the assertion module.
`ifndef EDTG_DEFINES_SVH
`define EDTG_DEFINES_SVH

// =====================================================================
// Register offsets
`define EDTG_OFF_CTRL 12'h000
`define EDTG_OFF_FILTER 12'h004
`define EDTG_OFF_DBG_STATUS 12'h008
`define EDTG_OFF_STATE 12'h00C
`define EDTG_OFF_LBR_COUNT 12'h010

// =====================================================================
// Field positions and reset values
`define EDTG_CTRL_BTF_BIT 0
`define EDTG_CTRL_LBR_BIT 1
`define EDTG_FILTER_FAR_BIT 8
`define EDTG_CTRL_RST 2'h0
`define EDTG_FILTER_RST 1'h0
`define EDTG_DSTAT_RST 4'h0
`define EDTG_NUM_BP 4

// =====================================================================
// Opcodes, vectors and event encodings
`define EDTG_OP_DEBUG_TRAP 8'hF1
`define EDTG_OP_BREAKPOINT 8'hCC
`define EDTG_VEC_DEBUG 8'h01
`define EDTG_VEC_BREAKPOINT 8'h03
`define EDTG_VEC_INVALID_OP 8'h06
`define EDTG_EVT_HW_EXC 3'h3
`define EDTG_INSTR_LEN_ZERO 4'h0
`define EDTG_PRED_BIT 63
`define EDTG_TXN_NONE 2'h0

`endif

// ==== edtg_pkg.sv ====
// Types shared by the enclave debug and trace gating block.
// Assumes the constants header sits in the same folder.
`include "edtg_defines.svh"

package edtg_pkg;

  // ===================================================================
  // Kind of the memory access reported with a data breakpoint match
  typedef enum logic [2:0] {
    EDTG_ACC_NORMAL = 3'b000,
    EDTG_ACC_IMPLICIT = 3'b001,
    EDTG_ACC_PRIV_LEAF = 3'b010,
    EDTG_ACC_ENTER_RESUME = 3'b011,
    EDTG_ACC_KEY_REPORT = 3'b100,
    EDTG_ACC_OTHER_LEAF = 3'b101
  } edtg_acc_t;

  // ===================================================================
  // Complete state of the block
  typedef struct packed {
    logic in_encl;
    logic optin;
    logic lbr_at_entry;
    logic [63:0] entry_ip;
    logic [1:0] ctrl;
    logic filt_far;
    logic [3:0] dstat;
    logic [15:0] lbr_count;
    logic [3:0] ibp_fire;
    logic [3:0] dbp_fire;
    logic step_exc;
    logic exc_valid;
    logic [7:0] exc_vec;
    logic exc_skip_dpl;
    logic [63:0] exc_ssa_ip;
    logic [63:0] exc_stack_ip;
    logic vmx_valid;
    logic [2:0] vmx_type;
    logic [3:0] vmx_len;
    logic rf_valid;
    logic rf_saved;
    logic lbr_push;
    logic [63:0] lbr_src;
    logic [63:0] lbr_tgt;
    logic pend_push;
    logic [63:0] pend_tgt;
    logic [63:0] pend_src;
    logic [31:0] prdata;
  } edtg_state_t;

endpackage

// ==== edtg_gate_asserts.sv ====
// Port assertions of the enclave debug and trace gating block.
// Assumes binding to edtg_gate; sees only its ports.
`timescale 1ns/10ps
`include "edtg_defines.svh"
module edtg_gate_asserts
  import edtg_pkg::*;
#(
  parameter int NUM_BP = 4
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic enter_i,
  input wire logic resume_i,
  input wire logic debug_optin_flag_i,
  input wire logic exit_i,
  input wire logic aex_i,
  input wire logic pushed_resume_flag_i,
  input wire logic [63:0] instr_ip_i,
  input wire logic [63:0] landing_addr_i,
  input wire logic [NUM_BP-1:0] ibp_match_i,
  input wire logic trap_op_valid_i,
  input wire logic [7:0] trap_opcode_i,
  input wire logic trap_vm_exit_i,
  input wire logic in_enclave_o,
  input wire logic optin_o,
  input wire logic [NUM_BP-1:0] ibp_fire_o,
  input wire logic step_exc_o,
  input wire logic exc_valid_o,
  input wire logic [7:0] exc_vector_o,
  input wire logic [63:0] exc_saved_ip_o,
  input wire logic [63:0] exc_stack_ip_o,
  input wire logic vmx_valid_o,
  input wire logic [2:0] vmx_event_type_o,
  input wire logic [3:0] vmx_instr_len_o,
  input wire logic rf_valid_o,
  input wire logic rf_saved_o,
  input wire logic rf_synth_o,
  input wire logic lbr_push_o,
  input wire logic [1:0] lbr_txn_tag_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  logic calm;
  logic trap;
  assign calm = ce_i && !exit_i && !aex_i;
  assign trap = calm && in_enclave_o && trap_op_valid_i
    && (trap_opcode_i == `EDTG_OP_DEBUG_TRAP || trap_opcode_i == `EDTG_OP_BREAKPOINT);
  // ====================================================================
  // Properties
  property p_entry;
    ce_i && !in_enclave_o && (enter_i || resume_i) && !exit_i
      |=> in_enclave_o && optin_o == $past(debug_optin_flag_i);
  endproperty
  a_entry: assert property (p_entry)
    else $error("entry class wrong");
  property p_held;
    in_enclave_o && !(ce_i && (exit_i || aex_i)) |=> in_enclave_o && $stable(optin_o);
  endproperty
  a_held: assert property (p_held)
    else $error("class not held");
  property p_optout_ibp;
    calm && in_enclave_o && !optin_o |=> ibp_fire_o == '0;
  endproperty
  a_optout_ibp: assert property (p_optout_ibp)
    else $error("ibp not suppressed");
  property p_ibp_pass;
    calm && !(in_enclave_o && !optin_o) |=> ibp_fire_o == $past(ibp_match_i);
  endproperty
  a_ibp_pass: assert property (p_ibp_pass)
    else $error("ibp wrongly gated");
  property p_rf;
    ce_i && in_enclave_o && aex_i && !exit_i
      |=> rf_valid_o && rf_saved_o == $past(pushed_resume_flag_i) && !rf_synth_o;
  endproperty
  a_rf: assert property (p_rf)
    else $error("resume flag wrong");
  property p_vec;
    trap |=> exc_valid_o && exc_vector_o == (!$past(optin_o) ? `EDTG_VEC_INVALID_OP
      : $past(trap_opcode_i) == `EDTG_OP_BREAKPOINT ? `EDTG_VEC_BREAKPOINT : `EDTG_VEC_DEBUG);
  endproperty
  a_vec: assert property (p_vec)
    else $error("trap vector wrong");
  property p_trap_ip;
    trap |=> exc_saved_ip_o == $past(instr_ip_i) && exc_stack_ip_o == $past(landing_addr_i);
  endproperty
  a_trap_ip: assert property (p_trap_ip)
    else $error("trap addresses wrong");
  property p_vmx;
    trap && trap_vm_exit_i |=> vmx_valid_o && vmx_event_type_o == 3'h3 && vmx_instr_len_o == 4'h0;
  endproperty
  a_vmx: assert property (p_vmx)
    else $error("vm exit info wrong");
  property p_no_step;
    ce_i && !exit_i && ((in_enclave_o && aex_i) || (!in_enclave_o && resume_i && !enter_i))
      |=> !step_exc_o;
  endproperty
  a_no_step: assert property (p_no_step)
    else $error("unexpected step exception");
  property p_optout_lbr;
    calm && in_enclave_o && !optin_o |=> !lbr_push_o;
  endproperty
  a_optout_lbr: assert property (p_optout_lbr)
    else $error("record pushed while suppressed");
  property p_txn;
    lbr_push_o |-> lbr_txn_tag_o == 2'h0;
  endproperty
  a_txn: assert property (p_txn)
    else $error("record tagged transactional");
endmodule // edtg_gate_asserts

bind edtg_gate edtg_gate_asserts #(.NUM_BP(NUM_BP)) u_chk (.*);

// ==== tb.sv ====
// Self-checking bench of the enclave debug and trace gating block.
// Assumes the design and its checker are compiled first.
`timescale 1ns/10ps
module tb;
  import edtg_pkg::*;
  logic clk_sys_i, rstn_i, ce_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic enter_i, resume_i, debug_optin_flag_i, exit_i, aex_i, aex_trap_cause_i;
  logic aex_event_push_i, pushed_resume_flag_i, trap_op_valid_i, trap_vm_exit_i, branch_i;
  logic branch_mispred_i, dbp_acc_protected_i, in_enclave_o, optin_o, step_exc_o, exc_valid_o;
  logic exc_skip_dpl_check_o, vmx_valid_o, rf_valid_o, rf_saved_o, rf_synth_o, lbr_push_o;
  logic [63:0] instr_ip_i, dest_ip_i, aex_event_tgt_i, saved_instr_pointer_i, landing_addr_i;
  logic [63:0] enclave_range_base_i, enclave_range_limit_i, dbp_addr_i, branch_src_i;
  logic [63:0] branch_tgt_i, exc_saved_ip_o, exc_stack_ip_o, lbr_source_o, lbr_target_o;
  logic [3:0] landing_ibp_match_i, ibp_match_i, dbp_match_i, ibp_fire_o, dbp_fire_o, st;
  logic [3:0] vmx_instr_len_o;
  logic [7:0] trap_opcode_i, exc_vector_o;
  logic [2:0] vmx_event_type_o;
  logic [1:0] lbr_txn_tag_o;
  edtg_acc_t dbp_acc_kind_i;
  int miscompares, n_checks, cycles;
  localparam logic [63:0] pred = 64'h8000000000000000;

  edtg_gate #(.NUM_BP(4)) uut (.*);

  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares = miscompares + 1;
      summarize;
    end
  end

  // ====================================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys_i);
    {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    rd = prdata_o;
    err = pslverr_o;
    {psel_i, penable_i} <= 2'h0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("prdata", e, rd);
  endtask

  task automatic step;
    @(posedge clk_sys_i);
    {enter_i, resume_i, exit_i, aex_i, trap_op_valid_i, branch_i} <= 6'h0;
    {ibp_match_i, dbp_match_i} <= 8'h0;
    #1;
  endtask

  task automatic ev(input int k, input logic oi, input logic [63:0] ip, input logic [63:0] d,
      input logic [7:0] op, input logic [3:0] fl);
    @(posedge clk_sys_i);
    {enter_i, resume_i, exit_i, aex_i, trap_op_valid_i, branch_i} <= 6'h20 >> k;
    debug_optin_flag_i <= oi;
    {instr_ip_i, saved_instr_pointer_i, branch_src_i} <= {ip, ip, ip};
    {dest_ip_i, landing_addr_i, branch_tgt_i, aex_event_tgt_i} <= {d, d, d, ~d};
    landing_ibp_match_i <= ip[3:0];
    trap_opcode_i <= op;
    {trap_vm_exit_i, aex_trap_cause_i, aex_event_push_i, pushed_resume_flag_i} <= fl;
    step;
  endtask

  task automatic rec(input logic p, input logic [63:0] s, input logic [63:0] t);
    chk("lbr_push", p, lbr_push_o);
    if (p) begin
      chk("lbr_src", s, lbr_source_o);
      chk("lbr_tgt", t, lbr_target_o);
      chk("lbr_txn", 2'h0, lbr_txn_tag_o);
    end
  endtask

  function automatic logic [3:0] dbp_exp(input logic ins, input logic oi, input logic [3:0] m,
      input edtg_acc_t k, input logic pr, input logic [63:0] a);
    logic rng;
    rng = a >= enclave_range_base_i && a <= enclave_range_limit_i;
    if (k == EDTG_ACC_IMPLICIT) return 4'h0;
    if (k == EDTG_ACC_NORMAL) return (ins && !oi && rng) ? 4'h0 : m;
    if (!pr) return m;
    return (k == EDTG_ACC_KEY_REPORT && ins && oi) ? m : 4'h0;
  endfunction

  task automatic burst(input logic ins, input logic oi);
    logic [3:0] xi, xd, ei, ed;
    logic [1:0] s;
    edtg_acc_t k;
    logic pr;
    logic [63:0] a;
    repeat (16) begin
      {xi, xd, s, pr} = 11'($urandom);
      k = edtg_acc_t'($urandom_range(0, 5));
      a = (s[1] ? 64'h1FFFFFFF : 64'hFFFFFFF) + 64'(s[0]);
      @(posedge clk_sys_i);
      {ibp_match_i, dbp_match_i, dbp_acc_kind_i, dbp_acc_protected_i, dbp_addr_i} <=
        {xi, xd, k, pr, a};
      step;
      ei = (ins && !oi) ? 4'h0 : xi;
      ed = dbp_exp(ins, oi, xd, k, pr, a);
      st = st | ei | ed;
      chk("ibp_fire", ei, ibp_fire_o);
      chk("dbp_fire", ed, dbp_fire_o);
    end
    rdc(12'h008, {28'h0, st});
  endtask

  task automatic traps(input logic oi);
    for (int i = 0; i < 2; i++) begin
      ev(4, oi, 64'h2000 + i, 64'h7000, i ? 8'hCC : 8'hF1, 4'h8);
      chk("exc", {1'b1, !oi ? 8'h06 : i ? 8'h03 : 8'h01}, {exc_valid_o, exc_vector_o});
      chk("skip_dpl", oi && i, exc_skip_dpl_check_o);
      chk("exc_ip", 64'h2000 + i, exc_saved_ip_o);
      chk("exc_stack", 64'h7000, exc_stack_ip_o);
      chk("vmx", 8'hB0, {vmx_valid_o, vmx_event_type_o, vmx_instr_len_o});
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ====================================================================
  // Main sequence
  initial begin
    {miscompares, n_checks, st} = '0;
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, enter_i, resume_i, exit_i, aex_i} = '0;
    {debug_optin_flag_i, aex_trap_cause_i, aex_event_push_i, pushed_resume_flag_i} = '0;
    {trap_op_valid_i, trap_vm_exit_i, branch_i, branch_mispred_i, dbp_acc_protected_i} = '0;
    {instr_ip_i, dest_ip_i, aex_event_tgt_i, saved_instr_pointer_i, landing_addr_i} = '0;
    {dbp_addr_i, branch_src_i, branch_tgt_i, landing_ibp_match_i, ibp_match_i} = '0;
    {dbp_match_i, trap_opcode_i} = '0;
    dbp_acc_kind_i = EDTG_ACC_NORMAL;
    enclave_range_base_i = 64'h10000000;
    enclave_range_limit_i = 64'h1FFFFFFF;
    ce_i = 1'b1;
    rstn_i = 1'b0;
    void'($urandom(32'hC208));
    repeat (16) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    for (int i = 0; i < 5; i++) rdc(12'(4 * i), 32'h0);
    rdc(12'h020, 32'h0);
    chk("pslverr", 1'b1, err);
    apb(1'b1, 12'h004, 32'hFFFFFFFF);
    rdc(12'h004, 32'h100);
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h000, 32'h3);
    rdc(12'h000, 32'h3);
    $display("test regs done");
    burst(1'b0, 1'b0);
    ev(0, 1'b1, 64'h400, 64'h10000040, 8'h0, 4'h0);
    chk("state", 2'h3, {optin_o, in_enclave_o});
    rec(1'b1, pred | 64'h400, 64'h10000040);
    chk("step", 1'b1, step_exc_o);
    burst(1'b1, 1'b1);
    ev(5, 1'b1, 64'h10000050, 64'h10000090, 8'h0, 4'h0);
    chk("br_push", 1'b1, lbr_push_o);
    chk("br_tgt", 64'h10000090, lbr_target_o);
    traps(1'b1);
    ev(3, 1'b1, 64'h10000083, 64'h9000, 8'h0, 4'h5);
    rec(1'b1, pred | 64'h10000083, 64'h9000);
    chk("rf", 4'hC, {rf_valid_o, rf_saved_o, rf_synth_o, step_exc_o});
    st = st | 4'h3;
    rdc(12'h008, {28'h0, st});
    apb(1'b1, 12'h008, {28'h0, st});
    st = 4'h0;
    rdc(12'h008, 32'h0);
    $display("test opt-in done");
    burst(1'b0, 1'b0);
    ev(1, 1'b0, 64'h500, 64'h10000100, 8'h0, 4'h0);
    chk("state", 3'h2, {optin_o, in_enclave_o, step_exc_o});
    rec(1'b0, 64'h0, 64'h0);
    burst(1'b1, 1'b0);
    ev(5, 1'b0, 64'h10000110, 64'h10000120, 8'h0, 4'h0);
    rec(1'b0, 64'h0, 64'h0);
    traps(1'b0);
    ev(2, 1'b0, 64'h600, 64'h3000, 8'h0, 4'h0);
    rec(1'b1, pred | 64'h500, 64'h3000);
    chk("step", 1'b1, step_exc_o);
    ev(5, 1'b0, 64'h3010, 64'h3020, 8'h0, 4'h0);
    chk("br_push", 1'b1, lbr_push_o);
    ev(0, 1'b0, 64'h700, 64'h10000200, 8'h0, 4'h0);
    chk("step", 1'b0, step_exc_o);
    ev(3, 1'b0, 64'h10000210, 64'h9100, 8'h0, 4'h2);
    rec(1'b1, pred | 64'h700, 64'h9100);
    chk("rf", 3'h4, {rf_valid_o, rf_saved_o, rf_synth_o});
    @(posedge clk_sys_i);
    #1;
    rec(1'b1, pred | 64'h9100, ~64'h9100);
    rdc(12'h010, 32'h7);
    $display("test opt-out done");
    apb(1'b1, 12'h004, 32'h100);
    ev(0, 1'b1, 64'h800, 64'h10000300, 8'h0, 4'h0);
    rec(1'b0, 64'h0, 64'h0);
    ev(2, 1'b1, 64'h10000310, 64'h3100, 8'h0, 4'h0);
    rec(1'b0, 64'h0, 64'h0);
    $display("test filter done");
    summarize;
  end
endmodule // tb
